// ==== hw/tsr_line_filter.v ====
// Purpose: Synchronise and glitch filter one bus line.
// Assumes: Input is asynchronous to the system clock.
// Notes: Output changes only after a stable run of samples.
`timescale 1ns/1ps
`include "tsr_defs.vh"
module tsr_line_filter
(
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst_b,
    // Line
    input wire i_line,
    output reg o_line
);
    reg sync_a;
    reg sync_b;
    reg [2:0] run;

    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
            run <= 3'h0;
            o_line <= 1'b1;
        end
        else
        begin
            sync_a <= i_line;
            sync_b <= sync_a;
            if (sync_b == o_line)
                run <= 3'h0;
            else if (run == `TSR_FILT_LEN - 1)
            begin
                run <= 3'h0;
                o_line <= sync_b;
            end
            else
                run <= run + 3'h1;
        end
    end
endmodule // tsr_line_filter

// ==== hw/tsr_readout.v ====
// Purpose: Digital side of a die temperature sensor with a two-wire slave port.
// Assumes: Converter delivers a 16-bit left-justified result with a done pulse.
// Notes: Registers reached only through the two-wire port; pointer at 0 gives result.
`timescale 1ns/1ps
`include "tsr_defs.vh"
module tsr_readout
#(
    parameter TOUT_CYC = `TSR_TOUT_CYC
)
(
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst_b,
    // Two-wire bus
    input wire i_scl,
    input wire i_sda,
    output reg o_sda,
    output reg o_sda_oe,
    // Address straps
    input wire [1:0] i_addr_pin,
    input wire i_addr_variant,
    // Converter
    input wire i_conv_done,
    input wire [15:0] i_conv_data,
    output reg o_conv_start,
    output reg o_shutdown
);
    localparam S_IDLE = 6'b000001;
    localparam S_ADDR = 6'b000010;
    localparam S_ACK = 6'b000100;
    localparam S_WBYTE = 6'b001000;
    localparam S_RBYTE = 6'b010000;
    localparam S_RACK = 6'b100000;

    wire scl_f;
    wire sda_f;
    reg scl_q;
    reg sda_q;
    reg [5:0] state;
    reg [7:0] shreg;
    reg [3:0] bitcnt;
    reg rd;
    reg [1:0] wcount;
    reg [2:0] ptr;
    reg byte_sel;
    reg [7:0] cfg;
    reg [7:0] ctrl;
    reg [15:0] temp;
    reg oneshot_busy;
    reg oneshot_wr;
    reg conv_active;
    reg [2:0] strap_a;
    reg [2:0] strap_b;
    reg [6:0] my_addr;
    reg [31:0] tout_cnt;

    function [15:0] res_mask;
        input [1:0] res;
        begin
            case (res)
                2'h0: res_mask = 16'hFFE0;
                2'h1: res_mask = 16'hFFF0;
                2'h2: res_mask = 16'hFFF8;
                default: res_mask = 16'hFFFC;
            endcase
        end
    endfunction

    function [7:0] reg_byte;
        input [2:0] p;
        input hi;
        begin
            case (p)
                `TSR_PTR_TEMP: reg_byte = hi ? temp[15:8] : temp[7:0];
                `TSR_PTR_CFG: reg_byte = cfg;
                `TSR_PTR_CTRL: reg_byte = ctrl;
                default: reg_byte = 8'h00;
            endcase
        end
    endfunction

    function ptr_ok;
        input [2:0] p;
        begin
            ptr_ok = (p == `TSR_PTR_TEMP) || (p == `TSR_PTR_CFG) || (p == `TSR_PTR_CTRL);
        end
    endfunction

    tsr_line_filter u_scl_filt
    (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_line(i_scl),
        .o_line(scl_f)
    );

    tsr_line_filter u_sda_filt
    (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_line(i_sda),
        .o_line(sda_f)
    );

    wire scl_rise = scl_f & ~scl_q;
    wire scl_fall = ~scl_f & scl_q;
    wire start_ev = scl_f & scl_q & sda_q & ~sda_f;
    wire stop_ev = scl_f & scl_q & ~sda_q & sda_f;
    wire tout = (tout_cnt >= TOUT_CYC - 1);
    wire [7:0] shifted = {shreg[6:0], sda_f};
    wire [7:0] rd_byte = reg_byte(ptr, byte_sel);

    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            strap_a <= 3'h0;
            strap_b <= 3'h0;
            my_addr <= {`TSR_ADDR_HI, `TSR_ADDR_V0_FLOAT};
        end
        else
        begin
            // Straps are pins, so they pass two flip-flops before decoding.
            strap_a <= {i_addr_variant, i_addr_pin};
            strap_b <= strap_a;
            case (strap_b[1:0])
                `TSR_PIN_FLOAT: my_addr <= {`TSR_ADDR_HI, strap_b[2] ? `TSR_ADDR_V1_FLOAT : `TSR_ADDR_V0_FLOAT};
                `TSR_PIN_GND: my_addr <= {`TSR_ADDR_HI, strap_b[2] ? `TSR_ADDR_V1_GND : `TSR_ADDR_V0_GND};
                default: my_addr <= {`TSR_ADDR_HI, strap_b[2] ? `TSR_ADDR_V1_VDD : `TSR_ADDR_V0_VDD};
            endcase
        end
    end

    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            tout_cnt <= 32'h0;
        else if (scl_f & sda_f)
            tout_cnt <= 32'h0;
        else if (!tout)
            tout_cnt <= tout_cnt + 32'h1;
    end

    // Serial slave machine; the data line is only ever pulled low or released.
    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state <= S_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            rd <= 1'b0;
            wcount <= 2'h0;
            ptr <= `TSR_PTR_TEMP;
            byte_sel <= 1'b1;
            o_sda <= 1'b0;
            o_sda_oe <= 1'b0;
            cfg <= `TSR_CFG_RST;
            oneshot_wr <= 1'b0;
            ctrl <= `TSR_CTRL_RST;
        end
        else
        begin
            scl_q <= scl_f;
            sda_q <= sda_f;
            o_sda <= 1'b0;
            oneshot_wr <= 1'b0;
            if (tout)
            begin
                state <= S_IDLE;
                o_sda_oe <= 1'b0;
            end
            else if (start_ev)
            begin
                state <= S_ADDR;
                bitcnt <= 4'h0;
                o_sda_oe <= 1'b0;
                byte_sel <= 1'b1;
            end
            else if (stop_ev)
            begin
                state <= S_IDLE;
                o_sda_oe <= 1'b0;
            end
            else
            begin
                case (state)
                    S_IDLE:
                        o_sda_oe <= 1'b0;
                    S_ADDR, S_WBYTE:
                        if (scl_rise)
                        begin
                            shreg <= shifted;
                            bitcnt <= bitcnt + 4'h1;
                        end
                        else if (scl_fall && bitcnt == 4'h8)
                        begin
                            bitcnt <= 4'h0;
                            if (state == S_ADDR)
                            begin
                                if (shreg[7:1] == my_addr)
                                begin
                                    o_sda_oe <= 1'b1;
                                    rd <= shreg[0];
                                    wcount <= 2'h0;
                                    state <= S_ACK;
                                end
                                else
                                    state <= S_IDLE;
                            end
                            else if (wcount == 2'h0 && !ptr_ok(shreg[2:0]))
                                state <= S_IDLE;
                            else
                            begin
                                o_sda_oe <= 1'b1;
                                state <= S_ACK;
                                if (wcount == 2'h0)
                                    ptr <= shreg[2:0];
                                else if (ptr == `TSR_PTR_CFG)
                                begin
                                    cfg <= shreg & `TSR_CFG_WMASK;
                                    oneshot_wr <= shreg[`TSR_CFG_ONESHOT];
                                end
                                else if (ptr == `TSR_PTR_CTRL)
                                    ctrl <= (ctrl & ~`TSR_CTRL_WMASK) | (shreg & `TSR_CTRL_WMASK);
                                if (wcount != 2'h3)
                                    wcount <= wcount + 2'h1;
                            end
                        end
                    S_ACK:
                        if (scl_fall)
                        begin
                            if (rd)
                            begin
                                shreg <= rd_byte;
                                o_sda_oe <= ~rd_byte[7];
                                bitcnt <= 4'h1;
                                state <= S_RBYTE;
                            end
                            else
                            begin
                                o_sda_oe <= 1'b0;
                                state <= S_WBYTE;
                            end
                        end
                    S_RBYTE:
                        if (scl_fall)
                        begin
                            if (bitcnt == 4'h8)
                            begin
                                o_sda_oe <= 1'b0;
                                byte_sel <= ~byte_sel;
                                state <= S_RACK;
                            end
                            else
                            begin
                                o_sda_oe <= ~shreg[6];
                                shreg <= {shreg[6:0], 1'b0};
                                bitcnt <= bitcnt + 4'h1;
                            end
                        end
                    S_RACK:
                        if (scl_rise)
                            state <= sda_f ? S_IDLE : S_ACK;
                    default:
                        state <= S_IDLE;
                endcase
            end
            // Flag updates come last so a finishing conversion wins over a host write.
            if (o_conv_start && oneshot_busy)
                ctrl[`TSR_CTRL_READY] <= 1'b0;
            if (conv_active && i_conv_done)
                ctrl[`TSR_CTRL_READY] <= 1'b1;
        end
    end

    // Converter sequencing and result register.
    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            temp <= `TSR_TEMP_RST;
            oneshot_busy <= 1'b0;
            conv_active <= 1'b0;
            o_conv_start <= 1'b0;
            o_shutdown <= 1'b0;
        end
        else
        begin
            o_conv_start <= 1'b0;
            o_shutdown <= cfg[`TSR_CFG_SHDN] & ~conv_active;
            if (conv_active && i_conv_done)
            begin
                conv_active <= 1'b0;
                oneshot_busy <= 1'b0;
                temp <= i_conv_data & res_mask(ctrl[`TSR_CTRL_RES_HI:`TSR_CTRL_RES_LO]);
            end
            else if (!conv_active && !o_conv_start)
            begin
                if (!cfg[`TSR_CFG_SHDN])
                begin
                    conv_active <= 1'b1;
                    o_conv_start <= 1'b1;
                end
                // A trigger written while a conversion is still finishing is dropped.
                else if (oneshot_wr)
                begin
                    conv_active <= 1'b1;
                    o_conv_start <= 1'b1;
                    oneshot_busy <= 1'b1;
                    temp <= `TSR_TEMP_ONESHOT;
                end
            end
        end
    end
endmodule // tsr_readout

// ==== inc/tsr_defs.vh ====
// Purpose: Constants for the temperature sensor readout block.
// Assumes: System clock of 40 MHz; times are given in their own units.
// Notes: Included by both design files.
`ifndef TSR_DEFS_VH
`define TSR_DEFS_VH
`define TSR_CLK_HZ 40000000
`define TSR_TOUT_MIN_MS 15
`define TSR_TOUT_MAX_MS 45
`define TSR_TOUT_MS 30
`define TSR_TOUT_CYC (`TSR_TOUT_MS * (`TSR_CLK_HZ / 1000))
`define TSR_FILT_LEN 4
`define TSR_PTR_TEMP 3'h0
`define TSR_PTR_CFG 3'h1
`define TSR_PTR_CTRL 3'h4
`define TSR_CFG_SHDN 7
`define TSR_CFG_ONESHOT 2
`define TSR_CFG_RST 8'h40
`define TSR_CFG_WMASK 8'hC0
`define TSR_CTRL_RES_HI 6
`define TSR_CTRL_RES_LO 5
`define TSR_CTRL_READY 0
`define TSR_CTRL_RST 8'h08
`define TSR_CTRL_WMASK 8'h60
`define TSR_TEMP_RST 16'h7FFC
`define TSR_TEMP_ONESHOT 16'h8000
`define TSR_ADDR_HI 4'h9
`define TSR_ADDR_V0_FLOAT 3'h0
`define TSR_ADDR_V0_GND 3'h1
`define TSR_ADDR_V0_VDD 3'h2
`define TSR_ADDR_V1_FLOAT 3'h4
`define TSR_ADDR_V1_GND 3'h5
`define TSR_ADDR_V1_VDD 3'h6
`define TSR_PIN_FLOAT 2'h0
`define TSR_PIN_GND 2'h1
`define TSR_PIN_VDD 2'h2
`endif

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the readout block.
// Assumes: Converter modelled here with a fixed conversion time.
// Notes: Timeout and conversion shortened so the run stays small.
`timescale 1ns/1ps
module testbench;
    localparam TOUT = 600;
    localparam CONV = 4000;
    localparam [15:0] CVAL = 16'h0D9E;
    reg clk;
    reg rst_b;
    reg [1:0] pin;
    reg variant;
    reg done = 1'b0;
    wire scl;
    wire host_low;
    wire sda_q;
    wire sda_oe;
    wire start;
    wire shdn;
    wire sda = !(host_low || (sda_oe && !sda_q));
    integer failures = 0;
    integer checks = 0;
    integer cyc = 0;
    integer cnt;
    integer r = 0;
    integer i;
    integer j;
    reg [6:0] dev;
    reg ack;
    reg [15:0] v;
    tsr_readout #(.TOUT_CYC(TOUT)) u_tsr_readout (.i_clk_sys(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda),
        .o_sda(sda_q), .o_sda_oe(sda_oe), .i_addr_pin(pin), .i_addr_variant(variant), .i_conv_done(done),
        .i_conv_data(CVAL), .o_conv_start(start), .o_shutdown(shdn));
    tsr_host u_tsr_host (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = !clk;
    end
    // Converter answers each start after a fixed time.
    always @(negedge clk)
    begin
        done <= (r == 1);
        if (start)
            r <= CONV;
        else if (r != 0)
            r <= r - 1;
    end
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 90000)
        begin
            failures = failures + 1;
            results;
        end
    end
    task results;
    begin
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    task chk(input [15:0] seen, input [15:0] exp);
    begin
        checks = checks + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    end
    endtask
    task wreg(input [7:0] p, input [7:0] d);
    begin
        u_tsr_host.start;
        u_tsr_host.wbyte({dev, 1'b0}, ack);
        u_tsr_host.wbyte(p, ack);
        u_tsr_host.wbyte(d, ack);
        u_tsr_host.stop;
    end
    endtask
    // Pointer is always set first, so reads never lean on an older pointer.
    task rreg(input [7:0] p, input integer n);
    begin
        u_tsr_host.start;
        u_tsr_host.wbyte({dev, 1'b0}, ack);
        u_tsr_host.wbyte(p, ack);
        u_tsr_host.start;
        u_tsr_host.wbyte({dev, 1'b1}, ack);
        v = 16'h0000;
        if (n == 2)
            u_tsr_host.rbyte(v[15:8], 1'b1);
        u_tsr_host.rbyte(v[7:0], 1'b0);
        u_tsr_host.stop;
    end
    endtask
    task probe(input [6:0] a, input e);
    begin
        u_tsr_host.start;
        u_tsr_host.wbyte({a, 1'b0}, ack);
        u_tsr_host.stop;
        chk({15'h0000, ack}, {15'h0000, e});
    end
    endtask
    task wdone;
    begin
        cnt = 0;
        while (done !== 1'b1 && cnt < 2 * CONV)
        begin
            @(posedge clk);
            cnt = cnt + 1;
        end
        chk({15'h0000, done}, 16'h0001);
        @(negedge clk);
    end
    endtask
    initial
    begin
        rst_b = 1'b0;
        pin = 2'h0;
        variant = 1'b0;
        dev = 7'h48;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        repeat (12) @(negedge clk);
        rreg(8'h00, 2);
        chk(v, 16'h7FFC);
        rreg(8'h04, 1);
        chk(v & 16'h0060, 16'h0000);
        wdone;
        rreg(8'h00, 2);
        chk(v, CVAL & 16'hFFE0);
        $display("test reset done");
        for (i = 0; i < 2; i = i + 1)
            for (j = 0; j < 3; j = j + 1)
            begin
                variant = i[0];
                pin = j[1:0];
                dev = {4'h9, i[0], j[1:0]};
                repeat (4) @(negedge clk);
                probe(dev, 1'b1);
                probe(dev ^ 7'h04, 1'b0);
            end
        variant = 1'b0;
        pin = 2'h0;
        dev = 7'h48;
        $display("test address done");
        for (i = 0; i < 4; i = i + 1)
        begin
            wreg(8'h04, {1'b0, i[1:0], 5'h00});
            rreg(8'h04, 1);
            chk(v & 16'h0060, {9'h000, i[1:0], 5'h00});
            wdone;
            rreg(8'h00, 2);
            chk(v, CVAL & ~(16'h001F >> i));
        end
        $display("test resolution done");
        wreg(8'h01, 8'h80);
        cnt = 0;
        while (shdn !== 1'b1 && cnt < 2 * CONV)
        begin
            @(negedge clk);
            cnt = cnt + 1;
        end
        chk({15'h0000, shdn}, 16'h0001);
        wreg(8'h01, 8'h84);
        rreg(8'h00, 2);
        chk(v, 16'h8000);
        rreg(8'h01, 1);
        chk(v, 16'h0080);
        rreg(8'h04, 1);
        chk(v & 16'h0061, 16'h0060);
        wdone;
        rreg(8'h04, 1);
        chk(v & 16'h0061, 16'h0061);
        rreg(8'h00, 2);
        chk(v, CVAL & 16'hFFFC);
        $display("test single conversion done");
        u_tsr_host.start;
        u_tsr_host.wbyte({dev, 1'b1}, ack);
        repeat (12) @(negedge clk);
        chk({15'h0000, sda_oe}, 16'h0001);
        repeat (TOUT + 100) @(negedge clk);
        chk({15'h0000, sda_oe}, 16'h0000);
        u_tsr_host.stop;
        rreg(8'h00, 2);
        chk(v, CVAL & 16'hFFFC);
        $display("test timeout done");
        results;
    end
endmodule // testbench
bind tsr_readout tsr_readout_props #(.TOUT_CYC(TOUT_CYC)) u_props (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_conv_done(i_conv_done),
    .o_conv_start(o_conv_start));

// ==== tb/tsr_host.sv ====
// Purpose: Bus master model driving clock and data.
// Assumes: Pull-up resolved by the bench.
// Notes: Phases are long enough to clear the input filter.
`timescale 1ns/1ps
module tsr_host
#(
    parameter HALF = 12
)
(
    // Clock
    input wire i_clk_sys,
    // Bus
    input wire i_sda,
    output reg o_scl,
    output reg o_sda_low
);
    initial
    begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task wt(input integer n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task start;
    begin
        wt(2);
        o_sda_low = 1'b0;
        wt(HALF);
        o_scl = 1'b1;
        wt(HALF);
        o_sda_low = 1'b1;
        wt(HALF);
        o_scl = 1'b0;
    end
    endtask
    task bitx(input b, output s);
    begin
        wt(2);
        o_sda_low = !b;
        wt(HALF - 2);
        o_scl = 1'b1;
        wt(HALF);
        s = i_sda;
        o_scl = 1'b0;
    end
    endtask
    task wbyte(input [7:0] d, output a);
        integer k;
        reg s;
    begin
        for (k = 7; k >= 0; k = k - 1)
            bitx(d[k], s);
        bitx(1'b1, s);
        a = !s;
    end
    endtask
    task rbyte(output [7:0] d, input more);
        integer k;
        reg s;
    begin
        for (k = 7; k >= 0; k = k - 1)
            bitx(1'b1, d[k]);
        bitx(!more, s);
    end
    endtask
    task stop;
    begin
        wt(2);
        o_sda_low = 1'b1;
        wt(HALF - 2);
        o_scl = 1'b1;
        wt(HALF);
        o_sda_low = 1'b0;
        wt(2 * HALF);
    end
    endtask
endmodule // tsr_host

// ==== tb/tsr_readout_props.sv ====
// Purpose: Port assertions for the readout block.
// Assumes: Bound onto tsr_readout by the bench.
// Notes: Counters stand in for long waits.
`timescale 1ns/1ps
module tsr_readout_props
#(
    parameter TOUT_CYC = 600
)
(
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst_b,
    // Bus and converter
    input wire i_scl,
    input wire i_sda,
    input wire o_sda,
    input wire o_sda_oe,
    input wire i_conv_done,
    input wire o_conv_start
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);
    integer low_cnt;
    integer oe_cnt;
    reg busy;
    always @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            low_cnt <= 0;
            oe_cnt <= 0;
            busy <= 1'b0;
        end
        else
        begin
            low_cnt <= (i_scl && i_sda) ? 0 : low_cnt + 1;
            oe_cnt <= o_sda_oe ? oe_cnt + 1 : 0;
            busy <= o_conv_start || (busy && !i_conv_done);
        end
    end
    a_oe_open_drain:
        assert property (o_sda_oe |-> !o_sda) else $error("data line driven high");
    a_start_pulse:
        assert property (o_conv_start |=> !o_conv_start) else $error("start pulse too long");
    a_one_conv:
        assert property (o_conv_start |-> !busy) else $error("start while converting");
    a_reset_quiet:
        assert property ($rose(i_rst_b) |-> !o_sda_oe && !o_conv_start) else $error("busy out of reset");
    a_timeout_free:
        assert property (low_cnt > TOUT_CYC + 16 |-> !o_sda_oe) else $error("stuck bus still driven");
    a_oe_bounded:
        assert property (oe_cnt < TOUT_CYC + 24) else $error("data held low too long");
    a_drive_scl_low:
        assert property ($changed(o_sda_oe) |-> !i_scl) else $error("data moved with clock high");
    a_filter_delay:
        assert property ($fell(i_scl) |=> $stable(o_sda_oe)[*3]) else $error("clock edge not filtered");
endmodule // tsr_readout_props
